// ===== design/cpi_map.svh
// Register map, field positions, reset values and timing for the charger control block
`ifndef CPI_MAP_SVH
`define CPI_MAP_SVH
`define CPI_ADDR_W       8
`define CPI_DATA_W       8
`define CPI_OFS_IRQ_FLAG 8'h00
`define CPI_OFS_IRQ_MASK 8'h01
`define CPI_OFS_POWER_PATH_CONTROL    8'h02
`define CPI_OFS_CHG_CTRL 8'h03
`define CPI_OFS_CHG_STAT 8'h04
`define CPI_IRQ_N        4
`define CPI_IRQ_BTN      0
`define CPI_IRQ_USB      1
`define CPI_IRQ_AC       2
`define CPI_IRQ_FAULT    3
`define CPI_MASK_RST     4'h0
`define CPI_POWER_PATH_CONTROL_RST    2'h0
`define CPI_PP_AC_SINK   0
`define CPI_PP_USB_SINK  1
`define CPI_CTRL_RST     4'h0
`define CPI_CTRL_EN      0
`define CPI_CTRL_TDIS    1
`define CPI_CTRL_ISEL_LO 2
`define CPI_CTRL_ISEL_HI 3
`define CPI_CLK_MHZ      40
`define CPI_T_REARM_US   32
`define CPI_T_DET_US     2
`define CPI_DET_CW       12
`define CPI_SYNC_W       13
`define CPI_CHK_SPAN     1000
`endif

// ===== design/cpi_pkg.sv
// Types shared by the charger control block
package cpi_pkg;
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_SC_TEST,
        ST_PRECHG,
        ST_FAST,
        ST_CV,
        ST_DONE,
        ST_DET_REM,
        ST_INS_SRC,
        ST_INS_DET
    } cpi_state_t;
endpackage : cpi_pkg

// ===== design/cpi_top.sv
// Charger sequencing, power path selection and host interrupt control
//
// Overview of operation
// - Any event or fault sets its flag and, unless its mask bit is set, pulls host_irq_n low.
// - Reading the flag register clears flags and releases host_irq_n.
// - A persisting fault keeps its flag and re-asserts host_irq_n within 32 us.
// - Mask bits only gate host_irq_n; flags and protection keep running.
// - Sources: button press, button release, USB status change, AC status change.
// - Input present above battery plus 190 mV, absent below plus 125 mV.
// - Source priority is AC, then USB, then battery.
// - A disconnected input gets its discharge sink switched on.
// - Host sink enable bits force the AC and USB sinks on.
// - With AC and USB both absent the battery feeds the system.
// - Enabling charge first runs a short-circuit test before charging.
// - Phases run precharge, then fast charge, then constant voltage.
// - Precharge current is a fixed tenth of the selected fast current.
// - With termination enabled, termination current reached in constant voltage sets term_current_flag.
// - Termination is suppressed while the input-limit or thermal loop acts.
// - Safety timer runs at half rate while charge current is reduced.
// - With termination enabled the charger turns off at termination current.
// - With termination disabled charging stays in constant voltage, no detection.
// - Below recharge, pull detection current; above low voltage restarts charging.
// - After removal, repeat insertion test until battery found or disabled.
// - Battery removal also sets pack_temp_error.
// - Every push-button transition sets button_change_flag.
`timescale 1ns/1ps
`include "cpi_map.svh"

module cpi_top (
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_reset,
    input  wire logic [`CPI_ADDR_W-1:0] i_addr,
    input  wire logic [`CPI_DATA_W-1:0] i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic      [`CPI_DATA_W-1:0] o_rdata,
    input  wire logic                   i_ac_above_hi,
    input  wire logic                   i_ac_above_lo,
    input  wire logic                   i_usb_above_hi,
    input  wire logic                   i_usb_above_lo,
    input  wire logic                   i_bat_above_sc,
    input  wire logic                   i_bat_above_lowv,
    input  wire logic                   i_bat_above_rch,
    input  wire logic                   i_bat_at_oreg,
    input  wire logic                   i_ichg_below_term,
    input  wire logic                   i_dpm_active,
    input  wire logic                   i_thermal_active,
    input  wire logic                   i_path_limit,
    input  wire logic                   i_button_level,
    input  wire logic                   i_timer_tick,
    output logic                        o_host_irq_n_out,
    output logic                        o_host_irq_n_oe,
    output logic                        o_sel_ac,
    output logic                        o_sel_usb,
    output logic                        o_sel_bat,
    output logic                        o_ac_sink_on,
    output logic                        o_usb_sink_on,
    output logic                        o_sc_test_src,
    output logic                        o_charge_on,
    output logic                        o_precharge_mode,
    output logic                        o_cv_mode,
    output logic      [1:0]             o_fast_charge_current_sel,
    output logic                        o_det_sink_on,
    output logic                        o_safety_tick
);
    localparam int DET_CYCLES = `CPI_T_DET_US * `CPI_CLK_MHZ;
    localparam int IRQ_MAX    = `CPI_T_REARM_US * `CPI_CLK_MHZ;
    // Checker window is capped; still inside the re-assert limit, so only stricter
    localparam int REARM_DLY  = (IRQ_MAX > `CPI_CHK_SPAN) ? `CPI_CHK_SPAN : IRQ_MAX;
    localparam logic [`CPI_DET_CW-1:0] DET_LAST = `CPI_DET_CW'(DET_CYCLES - 1);

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [`CPI_SYNC_W-1:0] sync1_reg;
    logic [`CPI_SYNC_W-1:0] sync2_reg;
    logic w_ac_hi, w_ac_lo, w_usb_hi, w_usb_lo, w_bat_sc, w_bat_lowv, w_bat_rch;
    logic w_bat_oreg, w_ichg_term, w_dpm, w_therm, w_plim, w_btn;

    // Stage one feeds stage two only; everything else reads stage two
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {i_ac_above_hi, i_ac_above_lo, i_usb_above_hi, i_usb_above_lo,
                          i_bat_above_sc, i_bat_above_lowv, i_bat_above_rch, i_bat_at_oreg,
                          i_ichg_below_term, i_dpm_active, i_thermal_active, i_path_limit,
                          i_button_level};
            sync2_reg <= sync1_reg;
        end
    end
    assign {w_ac_hi, w_ac_lo, w_usb_hi, w_usb_lo, w_bat_sc, w_bat_lowv, w_bat_rch,
            w_bat_oreg, w_ichg_term, w_dpm, w_therm, w_plim, w_btn} = sync2_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Input presence with hysteresis and power path
    logic ac_pres_reg, ac_pres_next, usb_pres_reg, usb_pres_next, btn_reg;

    // Separate set and clear comparators give the 65 mV hysteresis band
    assign ac_pres_next  = w_ac_hi | (ac_pres_reg & w_ac_lo);
    assign usb_pres_next = w_usb_hi | (usb_pres_reg & w_usb_lo);

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            ac_pres_reg  <= 1'b0;
            usb_pres_reg <= 1'b0;
            btn_reg      <= 1'b0;
        end else begin
            ac_pres_reg  <= ac_pres_next;
            usb_pres_reg <= usb_pres_next;
            btn_reg      <= w_btn;
        end
    end

    logic [1:0] power_path_control_reg;
    // Priority path selection
    assign o_sel_ac      = ac_pres_reg;
    assign o_sel_usb     = usb_pres_reg & ~ac_pres_reg;
    assign o_sel_bat     = ~ac_pres_reg & ~usb_pres_reg;
    // Discharge sinks, host bits can force them on
    assign o_ac_sink_on  = ~ac_pres_reg | power_path_control_reg[`CPI_PP_AC_SINK];
    assign o_usb_sink_on = ~usb_pres_reg | power_path_control_reg[`CPI_PP_USB_SINK];

    ////////////////////////////////////////////////////////////////////////////
    // Register decode
    logic [3:0] ctrl_reg;
    logic [`CPI_IRQ_N-1:0] mask_reg;
    logic w_sel_flag, w_sel_mask, w_sel_pp, w_sel_ctrl, w_sel_stat, w_flag_rd;
    logic w_chg_en, w_term_dis;

    assign w_sel_flag = (i_addr == `CPI_OFS_IRQ_FLAG);
    assign w_sel_mask = (i_addr == `CPI_OFS_IRQ_MASK);
    assign w_sel_pp   = (i_addr == `CPI_OFS_POWER_PATH_CONTROL);
    assign w_sel_ctrl = (i_addr == `CPI_OFS_CHG_CTRL);
    assign w_sel_stat = (i_addr == `CPI_OFS_CHG_STAT);
    assign w_flag_rd  = i_rd & w_sel_flag;
    assign w_chg_en   = ctrl_reg[`CPI_CTRL_EN];
    assign w_term_dis = ctrl_reg[`CPI_CTRL_TDIS];

    // Writable registers
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            mask_reg  <= `CPI_MASK_RST;
            power_path_control_reg <= `CPI_POWER_PATH_CONTROL_RST;
            ctrl_reg  <= `CPI_CTRL_RST;
        end else if (i_wr) begin
            if (w_sel_mask) mask_reg <= i_wdata[`CPI_IRQ_N-1:0];
            if (w_sel_pp) power_path_control_reg <= i_wdata[1:0];
            if (w_sel_ctrl) ctrl_reg <= i_wdata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Charger state machine
    cpi_pkg::cpi_state_t state_reg, state_next;
    logic [`CPI_DET_CW-1:0] det_cnt_reg;
    logic w_det_done, w_term_ok, w_restart, w_found;
    logic term_flag_reg, temp_err_reg, half_reg;

    assign w_det_done = (det_cnt_reg == DET_LAST);
    // Loops active means the low current is not real, so hold off termination
    assign w_term_ok  = ~w_term_dis & w_ichg_term & ~w_dpm & ~w_therm;

    // Next-state selection
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            cpi_pkg::ST_IDLE:    if (w_chg_en) state_next = cpi_pkg::ST_SC_TEST;
            cpi_pkg::ST_SC_TEST: if (w_bat_sc) state_next = cpi_pkg::ST_PRECHG;
            cpi_pkg::ST_PRECHG:  if (w_bat_lowv) state_next = cpi_pkg::ST_FAST;
            cpi_pkg::ST_FAST:    if (w_bat_oreg) state_next = cpi_pkg::ST_CV;
            cpi_pkg::ST_CV:      if (w_term_ok) state_next = cpi_pkg::ST_DONE;
            cpi_pkg::ST_DONE:    if (~w_bat_rch) state_next = cpi_pkg::ST_DET_REM;
            cpi_pkg::ST_DET_REM: begin
                if (w_det_done) begin
                    state_next = w_bat_lowv ? cpi_pkg::ST_PRECHG : cpi_pkg::ST_INS_SRC;
                end
            end
            cpi_pkg::ST_INS_SRC: begin
                if (w_det_done) begin
                    state_next = w_bat_rch ? cpi_pkg::ST_INS_DET : cpi_pkg::ST_PRECHG;
                end
            end
            cpi_pkg::ST_INS_DET: begin
                if (w_det_done) begin
                    state_next = w_bat_lowv ? cpi_pkg::ST_PRECHG : cpi_pkg::ST_INS_SRC;
                end
            end
            default:             state_next = cpi_pkg::ST_IDLE;
        endcase
        if (~w_chg_en) state_next = cpi_pkg::ST_IDLE;
    end

    assign w_restart = (state_next == cpi_pkg::ST_PRECHG) & (state_reg != cpi_pkg::ST_PRECHG);
    assign w_found   = w_restart & ((state_reg == cpi_pkg::ST_INS_SRC) |
                                    (state_reg == cpi_pkg::ST_INS_DET));

    // State, detection timer and charger status flags
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_reg     <= cpi_pkg::ST_IDLE;
            det_cnt_reg   <= '0;
            term_flag_reg <= 1'b0;
            temp_err_reg  <= 1'b0;
        end else begin
            state_reg   <= state_next;
            det_cnt_reg <= (state_next != state_reg) ? '0 : det_cnt_reg + 1'b1;
            if (state_reg == cpi_pkg::ST_CV && w_term_ok) begin
                term_flag_reg <= 1'b1;
            end else if (w_restart) begin
                term_flag_reg <= 1'b0;
            end
            if (state_reg == cpi_pkg::ST_DET_REM && w_det_done && ~w_bat_lowv) begin
                temp_err_reg <= 1'b1;
            end else if (w_found || ~w_chg_en) begin
                temp_err_reg <= 1'b0;
            end
        end
    end

    // Analog controls decoded from the phase
    assign o_sc_test_src    = (state_reg == cpi_pkg::ST_SC_TEST);
    assign o_precharge_mode = (state_reg == cpi_pkg::ST_PRECHG) |
                              (state_reg == cpi_pkg::ST_INS_SRC);
    assign o_cv_mode        = (state_reg == cpi_pkg::ST_CV);
    assign o_charge_on      = o_precharge_mode | (state_reg == cpi_pkg::ST_FAST) | o_cv_mode;
    assign o_det_sink_on    = (state_reg == cpi_pkg::ST_DET_REM) |
                              (state_reg == cpi_pkg::ST_INS_DET);
    // Precharge ratio is fixed in the analog stage; only the fast code is exported
    assign o_fast_charge_current_sel = ctrl_reg[`CPI_CTRL_ISEL_HI:`CPI_CTRL_ISEL_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Safety timer rate
    logic w_timed, w_reduced;
    assign w_timed   = (state_reg == cpi_pkg::ST_PRECHG) | (state_reg == cpi_pkg::ST_FAST);
    assign w_reduced = w_plim | w_dpm | w_therm;

    // Every other tick is swallowed while current is reduced
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            half_reg <= 1'b0;
        end else if (i_timer_tick && w_timed && w_reduced) begin
            half_reg <= ~half_reg;
        end
    end
    assign o_safety_tick = i_timer_tick & w_timed & (~w_reduced | half_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt flags and open-drain line
    logic [`CPI_IRQ_N-1:0] flag_reg, flag_next, w_irq_set;
    logic w_pending;

    // Fault term is a level, so it sets the flag again at the same edge as a read clears it
    assign w_irq_set = {temp_err_reg,
                        ac_pres_reg ^ ac_pres_next,
                        usb_pres_reg ^ usb_pres_next,
                        btn_reg ^ w_btn};
    assign flag_next = (w_flag_rd ? '0 : flag_reg) | w_irq_set;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // Mask gates only the pin
    assign w_pending        = |(flag_reg & ~mask_reg);
    assign o_host_irq_n_out = 1'b0;
    assign o_host_irq_n_oe  = w_pending;

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe
    logic [`CPI_DATA_W-1:0] rdata_reg, w_rmux;
    assign w_rmux = w_sel_flag ? `CPI_DATA_W'(flag_reg) :
                    w_sel_mask ? `CPI_DATA_W'(mask_reg) :
                    w_sel_pp   ? `CPI_DATA_W'(power_path_control_reg) :
                    w_sel_ctrl ? `CPI_DATA_W'(ctrl_reg) :
                    w_sel_stat ? `CPI_DATA_W'({usb_pres_reg, ac_pres_reg, temp_err_reg,
                                               term_flag_reg}) :
                    '0;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= i_rd ? w_rmux : '0;
        end
    end
    assign o_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_btn_irq_pin: assert property (
        (btn_reg != w_btn) && !mask_reg[`CPI_IRQ_BTN] |=> o_host_irq_n_oe)
        else $error("button edge did not pull irq line");
    a_read_clears: assert property (
        w_flag_rd && (w_irq_set == '0) |=> (flag_reg == '0) && !o_host_irq_n_oe)
        else $error("flag read did not clear and release");
    a_fault_rearm: assert property (
        w_flag_rd && temp_err_reg && !mask_reg[`CPI_IRQ_FAULT] |->
        ##[1:REARM_DLY] o_host_irq_n_oe)
        else $error("persisting fault did not re-assert irq");
    a_mask_keeps: assert property (
        (btn_reg != w_btn) && mask_reg[`CPI_IRQ_BTN] |=>
        flag_reg[`CPI_IRQ_BTN] && !o_host_irq_n_oe || (flag_reg & ~mask_reg) != '0)
        else $error("masked event lost its flag");
    a_ac_detect: assert property (
        w_ac_hi |=> o_sel_ac ##0 o_ac_sink_on == power_path_control_reg[`CPI_PP_AC_SINK])
        else $error("ac presence or sink wrong");
    a_ac_absent: assert property (!w_ac_lo |=> !o_sel_ac && o_ac_sink_on)
        else $error("ac not dropped below low margin");
    a_path_prio: assert property (
        usb_pres_reg |-> (o_sel_usb != ac_pres_reg) && !o_sel_bat)
        else $error("usb path priority wrong");
    a_usb_force: assert property (
        $rose(power_path_control_reg[`CPI_PP_USB_SINK]) |-> o_usb_sink_on)
        else $error("usb sink force ignored");
    a_sc_first: assert property (
        state_reg == cpi_pkg::ST_IDLE && w_chg_en |=>
        o_sc_test_src && !o_charge_on)
        else $error("charge started without short test");
    a_term_flag: assert property (
        state_reg == cpi_pkg::ST_CV && w_chg_en && w_ichg_term && !w_term_dis &&
        !w_dpm && !w_therm |=> term_flag_reg && !o_charge_on)
        else $error("termination not taken");
    a_term_hold: assert property (
        state_reg == cpi_pkg::ST_CV && (w_term_dis || w_dpm || w_therm) && w_chg_en
        |=> o_cv_mode)
        else $error("termination not suppressed");
    a_half_rate: assert property (
        o_safety_tick && w_reduced && i_timer_tick ##1 (w_timed && w_reduced)[*2]
        |-> !o_safety_tick || !i_timer_tick)
        else $error("safety timer not halved");
    a_removal_err: assert property (
        state_reg == cpi_pkg::ST_DET_REM && w_det_done && !w_bat_lowv && w_chg_en
        |=> temp_err_reg && o_precharge_mode)
        else $error("removal not flagged");
    a_det_length: assert property (
        $rose(o_det_sink_on) |-> o_det_sink_on[*8])
        else $error("detection current too short");

    // Source selection, status event flags, safety tick gating and idle outputs
    a_ac_prio: assert property (
        ac_pres_reg |-> o_sel_ac && !o_sel_usb && !o_sel_bat)
        else $error("ac not given first priority");
    a_bat_fallback: assert property (
        !ac_pres_reg && !usb_pres_reg |-> o_sel_bat && !o_sel_ac && !o_sel_usb)
        else $error("battery not routed to system");
    a_usb_sink: assert property (
        !usb_pres_reg |-> o_usb_sink_on)
        else $error("usb sink off while input absent");
    a_usb_change: assert property (
        (usb_pres_reg != usb_pres_next) |=> flag_reg[`CPI_IRQ_USB])
        else $error("usb change not flagged");
    a_ac_change: assert property (
        (ac_pres_reg != ac_pres_next) |=> flag_reg[`CPI_IRQ_AC])
        else $error("ac change not flagged");
    a_btn_flag: assert property (
        (btn_reg != w_btn) |=> flag_reg[`CPI_IRQ_BTN])
        else $error("button edge not flagged");
    a_tick_gated: assert property (
        !w_timed |-> !o_safety_tick)
        else $error("safety tick outside timed phases");
    a_idle_quiet: assert property (
        state_reg == cpi_pkg::ST_IDLE |-> !o_charge_on && !o_det_sink_on)
        else $error("charger active while idle");

endmodule : cpi_top

// ===== verification/cpi_host_line.sv
// Host side of the interrupt line: open-drain wire with its pull-up
`timescale 1ns/1ps
module cpi_host_line (
    input  wire logic i_drv_out,
    input  wire logic i_drv_oe,
    output logic      o_level_n
);
    // Released line floats up to the pull-up, never holds the last value
    assign o_level_n = i_drv_oe ? i_drv_out : 1'b1;
endmodule : cpi_host_line

// ===== verification/cpi_top_test.sv
// Register-level tests of the charger control block
`timescale 1ns/1ps
`include "cpi_map.svh"
module cpi_top_test;
    logic       clk, rst, wr, rd, tick, irq_n_out, irq_n_oe, line_n;
    logic [7:0] addr, wdata, rdata;
    logic       ac_hi, ac_lo, usb_hi, usb_lo, sc, lowv, rch, oreg, term, dpm, therm, plim, btn;
    logic       s_ac, s_usb, s_bat, k_ac, k_usb, sc_src, chg_on, pre, cv, det, stick;
    logic [1:0] fcs;
    int         err_count, n_compared, cyc;

    cpi_top dut (.i_clk_sys(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ac_above_hi(ac_hi), .i_ac_above_lo(ac_lo),
        .i_usb_above_hi(usb_hi), .i_usb_above_lo(usb_lo), .i_bat_above_sc(sc),
        .i_bat_above_lowv(lowv), .i_bat_above_rch(rch), .i_bat_at_oreg(oreg),
        .i_ichg_below_term(term), .i_dpm_active(dpm), .i_thermal_active(therm),
        .i_path_limit(plim), .i_button_level(btn), .i_timer_tick(tick),
        .o_host_irq_n_out(irq_n_out), .o_host_irq_n_oe(irq_n_oe), .o_sel_ac(s_ac),
        .o_sel_usb(s_usb), .o_sel_bat(s_bat), .o_ac_sink_on(k_ac), .o_usb_sink_on(k_usb),
        .o_sc_test_src(sc_src), .o_charge_on(chg_on), .o_precharge_mode(pre),
        .o_cv_mode(cv), .o_fast_charge_current_sel(fcs), .o_det_sink_on(det),
        .o_safety_tick(stick));
    cpi_host_line host (.i_drv_out(irq_n_out), .i_drv_oe(irq_n_oe), .o_level_n(line_n));

    // Clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic final_report;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val

    // Settle one ns past the edge so comb outputs have landed
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 chk_val($sformatf("reg %h", a), e, rdata);
    endtask : rd_chk

    // Four timer pulses, count those passed on
    task automatic ticks(input logic [7:0] e);
        logic [7:0] n;
        n = 8'h00;
        repeat (4) begin
            @(posedge clk);
            tick <= 1'b1;
            #1 n = n + {7'h00, stick};
            @(posedge clk);
            tick <= 1'b0;
        end
        chk_val("safety ticks", e, n);
    endtask : ticks

    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        {wr, rd, tick, ac_hi, ac_lo, usb_hi, usb_lo, sc, lowv, rch} = '0;
        {oreg, term, dpm, therm, plim, btn, addr, wdata} = '0;
        err_count = 0;
        n_compared = 0;
        cyc = 0;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        step(2);
        chk_bit("sel_bat", 1'b1, s_bat);
        chk_val("sinks", 8'h03, {6'h0, k_usb, k_ac});
        rd_chk(8'h01, 8'h00);
        rd_chk(8'h03, 8'h00);
        wr_reg(8'h04, 8'hff);
        wr_reg(8'h07, 8'hff);
        rd_chk(8'h04, 8'h00);
        rd_chk(8'h07, 8'h00);
        $display("Test reset and map done");

        btn <= 1'b1;
        step(5);
        chk_bit("irq line", 1'b0, line_n);
        rd_chk(8'h00, 8'h01);
        chk_bit("irq line", 1'b1, line_n);
        wr_reg(8'h01, 8'h01);
        btn <= 1'b0;
        step(5);
        chk_bit("irq line", 1'b1, line_n);
        rd_chk(8'h00, 8'h01);
        wr_reg(8'h01, 8'h00);
        $display("Test button interrupt done");

        ac_hi <= 1'b1;
        ac_lo <= 1'b1;
        step(5);
        chk_val("sel", 8'h04, {5'h0, s_ac, s_usb, s_bat});
        chk_bit("ac sink", 1'b0, k_ac);
        wr_reg(8'h02, 8'h01);
        step(1);
        chk_bit("ac sink forced", 1'b1, k_ac);
        wr_reg(8'h02, 8'h00);
        usb_hi <= 1'b1;
        usb_lo <= 1'b1;
        ac_hi <= 1'b0;
        step(5);
        chk_val("sel", 8'h04, {5'h0, s_ac, s_usb, s_bat});
        rd_chk(8'h04, 8'h0c);
        ac_lo <= 1'b0;
        step(5);
        chk_val("sel", 8'h02, {5'h0, s_ac, s_usb, s_bat});
        chk_val("sinks", 8'h01, {6'h0, k_usb, k_ac});
        wr_reg(8'h02, 8'h02);
        step(1);
        chk_bit("usb sink", 1'b1, k_usb);
        wr_reg(8'h02, 8'h00);
        rd_chk(8'h00, 8'h06);
        $display("Test power path done");

        wr_reg(8'h03, 8'h09);
        step(2);
        chk_val("sc test", 8'h02, {6'h0, sc_src, chg_on});
        sc <= 1'b1;
        step(5);
        chk_val("precharge", 8'h03, {6'h0, pre, chg_on});
        chk_val("current sel", 8'h02, {6'h0, fcs});
        ticks(8'h04);
        plim <= 1'b1;
        step(3);
        ticks(8'h02);
        plim <= 1'b0;
        lowv <= 1'b1;
        dpm <= 1'b1;
        step(5);
        chk_val("fast", 8'h01, {5'h0, cv, pre, chg_on});
        ticks(8'h02);
        dpm <= 1'b0;
        oreg <= 1'b1;
        rch <= 1'b1;
        step(5);
        chk_bit("cv mode", 1'b1, cv);
        term <= 1'b1;
        therm <= 1'b1;
        step(5);
        chk_val("cv held", 8'h03, {6'h0, cv, chg_on});
        therm <= 1'b0;
        step(5);
        chk_val("done", 8'h00, {6'h0, cv, chg_on});
        rd_chk(8'h04, 8'h09);
        $display("Test charge cycle done");

        {rch, oreg, lowv, term} <= 4'h0;
        step(5);
        chk_bit("det sink", 1'b1, det);
        step(82);
        rch <= 1'b1;
        chk_val("insert src", 8'h03, {6'h0, pre, chg_on});
        rd_chk(8'h04, 8'h0b);
        rd_chk(8'h00, 8'h08);
        step(2);
        chk_bit("irq again", 1'b0, line_n);
        wr_reg(8'h01, 8'h08);
        step(2);
        chk_bit("irq masked", 1'b1, line_n);
        rd_chk(8'h00, 8'h08);
        wr_reg(8'h03, 8'h00);
        rd_chk(8'h00, 8'h08);
        rd_chk(8'h00, 8'h00);
        wr_reg(8'h01, 8'h00);
        step(2);
        chk_bit("irq line", 1'b1, line_n);
        $display("Test detection done");

        {sc, lowv, oreg, rch, term} <= 5'h1f;
        wr_reg(8'h03, 8'h0b);
        step(10);
        chk_bit("cv mode", 1'b1, cv);
        rch <= 1'b0;
        step(90);
        chk_val("cv stays", 8'h02, {6'h0, cv, det});
        wr_reg(8'h03, 8'h00);
        $display("Test no termination done");

        rch <= 1'b1;
        wr_reg(8'h03, 8'h09);
        step(10);
        chk_val("done again", 8'h00, {6'h0, cv, chg_on});
        {oreg, rch} <= 2'h0;
        step(85);
        chk_val("recharge", 8'h04, {5'h0, chg_on, pre, det});
        rd_chk(8'h04, 8'h08);
        wr_reg(8'h03, 8'h00);
        $display("Test recharge done");
        final_report();
    end
endmodule : cpi_top_test
